//--- hdl/uif_pkg.sv
// Package: register map, fields and constants of the serial channel
package uif_pkg;
    // Byte addresses on APB
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TXRX = 8'h08;
    localparam logic [7:0] ADDR_DLY = 8'h0C;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    // Control register bits
    localparam int CTL_TEN = 0;
    localparam int CTL_REN = 1;
    localparam int CTL_TIN = 2;
    localparam int CTL_RIN = 3;
    localparam int CTL_TIS = 4;
    localparam int CTL_CTS = 5;
    localparam int CTL_RTS = 6;
    // Mode register bits
    localparam int MOD_LEN9 = 0;
    localparam int MOD_PEN = 1;
    localparam int MOD_PODD = 2;
    localparam int MOD_AME = 3;
    // Status register bits
    localparam int ST_TBE = 0;
    localparam int ST_TCM = 1;
    localparam int ST_RBF = 2;
    localparam int ST_OER = 3;
    localparam int ST_FER = 4;
    localparam int ST_PER = 5;
    localparam int ST_SER = 6;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_DIV = CLK_HZ / BAUD_HZ;
    localparam int HALF_DIV = BIT_DIV / 2;
    localparam int DLY_STEP = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] MODE_RST = 4'h0;

    typedef struct packed {
        logic txIrq;
        logic rxFullIrq;
        logic errSumIrq;
    } uif_irq_t;

    typedef struct packed {
        logic txd;
        logic rtsN;
        logic txActive;
    } uif_pins_t;
endpackage

//--- hdl/uif_uart.sv
// Serial channel with interrupts, CTS/RTS flow control and address mode
//
// How it works
// - TX_IRQ_SOURCE_SEL=0: transmit interrupt pulses when buffer-empty flag sets.
// - TX_IRQ_SOURCE_SEL=1: transmit interrupt pulses when transmission-complete flag sets.
// - Error-free reception completion pulses the receive-full interrupt, except for data in address mode.
// - Overrun, framing or parity error pulses the error-sum interrupt.
// - CTS enabled: transmission starts only while clear-to-send is low.
// - Started frame always completes even if clear-to-send rises.
// - Clearing transmit enable mid-frame lets the frame finish on the pin.
// - CTS disabled: transmission starts as soon as buffer holds data.
// - RTS pin follows receive state only with RTS enable bit set.
// - Setting receiver enable drives request-to-send low.
// - After last stop bit with receiver enabled, RTS low after delay.
// - RTS high on start, enable clear, disabled completion, init.
// - Four-bit delay field sets reassertion delay from mid stop bit.
// - Start bit during countdown abandons it; next stop restarts fully.
// - Address mode: top bit one means address, zero means data.
// - Error-free address sets full flag, interrupt, clears address mode.
// - Error-free data in address mode sets full flag, no interrupt.
// - Framing or parity error: error flags and error-sum interrupt only.
// - In address mode overrun is suppressed after the first character.
// - First character after enabling address mode may still overrun.
// - Outside address mode the top bit affects nothing.
// - Overrun when new character completes before data read, or before status read after an error.
// - Error flags clear on status read, reset or receiver init.
// - Buffer-empty sets on shift-register load, clears on buffer write.
`timescale 1ns/1ps
module uif_uart
    import uif_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic rxd, // Serial input pin
    input wire logic clear_to_send_n, // CTS pin, low active
    output uif_pkg::uif_pins_t pins, // TXD, RTS, tx activity
    output uif_pkg::uif_irq_t irq // Interrupt pulses to core
);
    import uif_pkg::*;

    typedef enum {TX_IDLE, TX_SHIFT} uif_txst_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA} uif_rxst_t;

    ////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] rxdSync_ff;
    logic [1:0] ctsSync_ff;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rxdSync_ff <= 2'h3;
            ctsSync_ff <= 2'h3;
        end
        else
        begin
            rxdSync_ff <= {rxdSync_ff[0], rxd};
            ctsSync_ff <= {ctsSync_ff[0], clear_to_send_n};
        end
    end
    logic rxdS;
    logic ctsLow;
    assign rxdS = rxdSync_ff[1];
    assign ctsLow = ~ctsSync_ff[1];

    ////////////////////////////////////////////////////////////////
    // APB decode
    logic wrEn;
    logic rdEn;
    logic mapped;
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT)
        || (paddr == ADDR_TXRX) || (paddr == ADDR_DLY)
        || (paddr == ADDR_MODE);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    logic wrCtrl;
    logic wrTxb;
    logic rdStat;
    logic rdRxb;
    assign wrCtrl = wrEn && paddr == ADDR_CTRL;
    assign wrTxb = wrEn && paddr == ADDR_TXRX;
    assign rdStat = rdEn && paddr == ADDR_STAT;
    assign rdRxb = rdEn && paddr == ADDR_TXRX;

    logic [7:0] ctrl_ff;
    logic [3:0] mode_ff;
    logic [3:0] rts_delay_count;
    logic [8:0] txBuf_ff;
    logic clrAme;
    logic transmitter_enable;
    logic recvEnable;
    logic tx_irq_source_sel;
    logic ctsSel;
    logic rtsSel;
    logic address_mode_enable;
    logic char_length_sel;
    logic txInit;
    logic receiver_init;
    assign transmitter_enable = ctrl_ff[CTL_TEN];
    assign recvEnable = ctrl_ff[CTL_REN];
    assign tx_irq_source_sel = ctrl_ff[CTL_TIS];
    assign ctsSel = ctrl_ff[CTL_CTS];
    assign rtsSel = ctrl_ff[CTL_RTS];
    assign address_mode_enable = mode_ff[MOD_AME];
    assign char_length_sel = mode_ff[MOD_LEN9];
    assign txInit = wrCtrl & pwdata[CTL_TIN];
    assign receiver_init = wrCtrl & pwdata[CTL_RIN];

    // Init bits self-clear; all other written bits, including unused bit 7, are kept
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ctrl_ff <= CTRL_RST;
        else if (wrCtrl)
            ctrl_ff <= pwdata[7:0] & ~(8'h01 << CTL_TIN)
                & ~(8'h01 << CTL_RIN);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            mode_ff <= MODE_RST;
        else if (wrEn && paddr == ADDR_MODE)
            mode_ff <= pwdata[3:0];
        else if (clrAme)
            mode_ff[MOD_AME] <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rts_delay_count <= 4'h0;
        else if (wrEn && paddr == ADDR_DLY)
            rts_delay_count <= pwdata[3:0];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            txBuf_ff <= 9'h000;
        else if (wrTxb)
            txBuf_ff <= pwdata[8:0];
    end

    ////////////////////////////////////////////////////////////////
    // Transmitter
    uif_txst_t txSt_ff;
    logic [15:0] txDiv_ff;
    logic [3:0] txBit_ff;
    logic [10:0] txShift_ff;
    logic tx_buffer_empty_flag;
    logic tx_complete_flag;
    logic txStart;
    logic txLastDone;
    logic txOk;
    logic [3:0] txBits;
    assign txBits = char_length_sel ? 4'd10 : 4'd9;
    // CTS gates only the start of a frame
    assign txOk = transmitter_enable && !tx_buffer_empty_flag
        && (!ctsSel || ctsLow);
    assign txLastDone = txSt_ff == TX_SHIFT && txDiv_ff == 16'd0
        && txBit_ff == txBits;
    assign txStart = txOk && (txSt_ff == TX_IDLE || txLastDone);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            txSt_ff <= TX_IDLE;
            txDiv_ff <= 16'd0;
            txBit_ff <= 4'd0;
            txShift_ff <= 11'h7FF;
        end
        else if (txStart)
        begin
            txSt_ff <= TX_SHIFT;
            txDiv_ff <= 16'(BIT_DIV - 1);
            txBit_ff <= 4'd0;
            txShift_ff <= char_length_sel ? {1'b1, txBuf_ff, 1'b0}
                : {2'b11, txBuf_ff[7:0], 1'b0};
        end
        else if (txSt_ff == TX_SHIFT)
        begin
            // Runs to the stop bit regardless of enable or CTS
            if (txDiv_ff != 16'd0)
                txDiv_ff <= txDiv_ff - 16'd1;
            else if (txBit_ff == txBits)
                txSt_ff <= TX_IDLE;
            else
            begin
                txDiv_ff <= 16'(BIT_DIV - 1);
                txBit_ff <= txBit_ff + 4'd1;
                txShift_ff <= {1'b1, txShift_ff[10:1]};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tx_buffer_empty_flag <= 1'b1;
        else if (txStart || txInit)
            tx_buffer_empty_flag <= 1'b1;
        else if (wrTxb)
            tx_buffer_empty_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tx_complete_flag <= 1'b1;
        else if (txInit || (txLastDone && !txStart))
            tx_complete_flag <= 1'b1;
        else if (txStart)
            tx_complete_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Receiver
    uif_rxst_t rxSt_ff;
    logic [15:0] rxDiv_ff;
    logic [3:0] rxBit_ff;
    logic [9:0] rxShift_ff;
    logic [8:0] rxBuf_ff;
    logic rx_buffer_full_flag;
    logic overrun_flag;
    logic framErr_ff;
    logic parErr_ff;
    logic amePrimed_ff;
    logic rxStartValid;
    logic rxDone;
    logic [3:0] rxBits;
    logic [3:0] dataBits;
    logic [8:0] dataWord;
    logic parBit;
    logic parBad;
    logic frameBad;
    logic topBit;
    logic prevUnread;
    logic ovr;
    assign dataBits = char_length_sel ? 4'd9 : 4'd8;
    assign rxBits = dataBits + {3'b000, mode_ff[MOD_PEN]};
    assign rxStartValid = rxSt_ff == RX_START && rxDiv_ff == 16'd0
        && !rxdS;
    assign rxDone = rxSt_ff == RX_DATA && rxDiv_ff == 16'd0
        && rxBit_ff == rxBits;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rxSt_ff <= RX_IDLE;
            rxDiv_ff <= 16'd0;
            rxBit_ff <= 4'd0;
            rxShift_ff <= 10'h000;
        end
        else if (receiver_init)
            rxSt_ff <= RX_IDLE;
        else unique case (rxSt_ff)
            RX_IDLE:
                if (recvEnable && !rxdS)
                begin
                    rxSt_ff <= RX_START;
                    rxDiv_ff <= 16'(HALF_DIV - 1);
                end
            RX_START:
                if (rxDiv_ff != 16'd0)
                    rxDiv_ff <= rxDiv_ff - 16'd1;
                else if (rxdS)
                    rxSt_ff <= RX_IDLE;
                else
                begin
                    rxSt_ff <= RX_DATA;
                    rxDiv_ff <= 16'(BIT_DIV - 1);
                    rxBit_ff <= 4'd0;
                end
            RX_DATA:
                if (rxDiv_ff != 16'd0)
                    rxDiv_ff <= rxDiv_ff - 16'd1;
                else if (rxBit_ff == rxBits)
                    rxSt_ff <= RX_IDLE;
                else
                begin
                    rxDiv_ff <= 16'(BIT_DIV - 1);
                    rxBit_ff <= rxBit_ff + 4'd1;
                    rxShift_ff <= {rxdS, rxShift_ff[9:1]};
                end
        endcase
    end

    // Align shifted bits: data LSB first, optional parity last
    assign dataWord = char_length_sel
        ? (mode_ff[MOD_PEN] ? rxShift_ff[8:0] : rxShift_ff[9:1])
        : (mode_ff[MOD_PEN] ? {1'b0, rxShift_ff[8:1]}
        : {1'b0, rxShift_ff[9:2]});
    assign parBit = rxShift_ff[9];
    assign parBad = mode_ff[MOD_PEN]
        && ((^dataWord) ^ parBit ^ mode_ff[MOD_PODD]);
    assign frameBad = !rxdS;
    assign topBit = char_length_sel ? dataWord[8] : dataWord[7];
    assign prevUnread = rx_buffer_full_flag || framErr_ff || parErr_ff
        || overrun_flag;
    // Address mode ignores overrun after its first character
    assign ovr = prevUnread && (!address_mode_enable || !amePrimed_ff);
    assign clrAme = rxDone && address_mode_enable && !parBad
        && !frameBad && topBit;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rxBuf_ff <= 9'h000;
        else if (rxDone && !parBad && !frameBad)
            rxBuf_ff <= dataWord;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            amePrimed_ff <= 1'b0;
        else if (!address_mode_enable || receiver_init)
            amePrimed_ff <= 1'b0;
        else if (rxDone)
            amePrimed_ff <= 1'b1;
    end

    // Set wins over clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rx_buffer_full_flag <= 1'b0;
        else if (rxDone && !parBad && !frameBad)
            rx_buffer_full_flag <= 1'b1;
        else if (rdRxb || receiver_init)
            rx_buffer_full_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            overrun_flag <= 1'b0;
            framErr_ff <= 1'b0;
            parErr_ff <= 1'b0;
        end
        else if (receiver_init)
        begin
            overrun_flag <= 1'b0;
            framErr_ff <= 1'b0;
            parErr_ff <= 1'b0;
        end
        else if (rxDone)
        begin
            overrun_flag <= ovr | (overrun_flag & ~rdStat);
            framErr_ff <= frameBad | (framErr_ff & ~rdStat);
            parErr_ff <= parBad | (parErr_ff & ~rdStat);
        end
        else if (rdStat)
        begin
            overrun_flag <= 1'b0;
            framErr_ff <= 1'b0;
            parErr_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupt pulses
    logic tbeRise;
    logic tcmRise;
    logic tbeDly_ff;
    logic tcmDly_ff;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tbeDly_ff <= 1'b1;
            tcmDly_ff <= 1'b1;
        end
        else
        begin
            tbeDly_ff <= tx_buffer_empty_flag;
            tcmDly_ff <= tx_complete_flag;
        end
    end
    assign tbeRise = tx_buffer_empty_flag && !tbeDly_ff;
    assign tcmRise = tx_complete_flag && !tcmDly_ff;

    logic rx_error_sum;
    assign rx_error_sum = overrun_flag | framErr_ff | parErr_ff;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            irq <= '0;
        else
        begin
            irq.txIrq <= tx_irq_source_sel ? tcmRise : tbeRise;
            irq.rxFullIrq <= rxDone && !parBad && !frameBad
                && !ovr && (!address_mode_enable || topBit);
            irq.errSumIrq <= rxDone && (parBad || frameBad || ovr);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Request-to-send control
    logic rtsHigh_ff;
    logic [15:0] dlyDiv_ff;
    logic [6:0] dlyBits_ff;
    logic dlyRun_ff;
    logic renDly_ff;
    logic midStop;
    logic [6:0] dlyTotal;
    assign dlyTotal = 7'(rts_delay_count * DLY_STEP);
    assign midStop = rxSt_ff == RX_DATA && rxBit_ff == rxBits
        && rxDiv_ff == 16'd0;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            renDly_ff <= 1'b0;
        else
            renDly_ff <= recvEnable;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rtsHigh_ff <= 1'b1;
            dlyRun_ff <= 1'b0;
            dlyDiv_ff <= 16'd0;
            dlyBits_ff <= 7'd0;
        end
        else if (receiver_init || rxStartValid)
        begin
            rtsHigh_ff <= 1'b1;
            dlyRun_ff <= 1'b0;
        end
        else if (!recvEnable && (renDly_ff || rxDone))
        begin
            rtsHigh_ff <= 1'b1;
            dlyRun_ff <= 1'b0;
        end
        else if (recvEnable && !renDly_ff)
            rtsHigh_ff <= 1'b0;
        else if (midStop && recvEnable)
        begin
            dlyRun_ff <= 1'b1;
            dlyDiv_ff <= 16'(BIT_DIV - 1);
            dlyBits_ff <= dlyTotal;
        end
        else if (dlyRun_ff)
        begin
            if (dlyBits_ff == 7'd0)
            begin
                dlyRun_ff <= 1'b0;
                rtsHigh_ff <= 1'b0;
            end
            else if (dlyDiv_ff != 16'd0)
                dlyDiv_ff <= dlyDiv_ff - 16'd1;
            else
            begin
                dlyDiv_ff <= 16'(BIT_DIV - 1);
                dlyBits_ff <= dlyBits_ff - 7'd1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pins <= '{txd: 1'b1, rtsN: 1'b1, txActive: 1'b0};
        else
        begin
            pins.txd <= txSt_ff == TX_SHIFT ? txShift_ff[0] : 1'b1;
            pins.rtsN <= rtsSel ? rtsHigh_ff : 1'b1;
            pins.txActive <= txSt_ff == TX_SHIFT;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data
    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL: rdMux[7:0] = ctrl_ff;
            ADDR_STAT:
            begin
                rdMux[ST_TBE] = tx_buffer_empty_flag;
                rdMux[ST_TCM] = tx_complete_flag;
                rdMux[ST_RBF] = rx_buffer_full_flag;
                rdMux[ST_OER] = overrun_flag;
                rdMux[ST_FER] = framErr_ff;
                rdMux[ST_PER] = parErr_ff;
                rdMux[ST_SER] = rx_error_sum;
            end
            ADDR_TXRX: rdMux[8:0] = rxBuf_ff;
            ADDR_DLY: rdMux[3:0] = rts_delay_count;
            ADDR_MODE: rdMux[3:0] = mode_ff;
            default: rdMux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rdMux;
    end
endmodule

//--- test/uif_uart_properties.sv
// Concurrent checks on the serial channel ports
`timescale 1ns/1ps
module uif_uart_properties
    import uif_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic rxd, // Serial input
    input wire logic clear_to_send_n, // CTS pin
    input uif_pkg::uif_pins_t pins, // Output pins
    input uif_pkg::uif_irq_t irq // Interrupt pulses
);
    import uif_pkg::*;
    localparam int MIN_FRAME = 9 * BIT_DIV;
    logic [7:0] ctl_ff;
    logic [11:0] txLen_ff;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the control register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ctl_ff <= CTRL_RST;
        else if (psel && penable && pwrite && paddr == ADDR_CTRL)
            ctl_ff <= pwdata[7:0];
    end
    // Length of the current frame
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            txLen_ff <= 12'h000;
        else if (pins.txActive)
            txLen_ff <= txLen_ff + 12'h001;
        else
            txLen_ff <= 12'h000;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence sTxStart;
        $rose(pins.txActive);
    endsequence
    a_tx_pulse: assert property (irq.txIrq |=> !irq.txIrq)
        else $error("tx interrupt wider than one cycle");
    a_tbe_irq: assert property (sTxStart ##0 !ctl_ff[CTL_TIS]
        |-> ##[0:6] irq.txIrq)
        else $error("no buffer-empty interrupt at frame start");
    a_tcm_irq: assert property (ctl_ff[CTL_TIS] && irq.txIrq
        |-> !pins.txActive)
        else $error("complete interrupt during a frame");
    a_cts_gate: assert property (sTxStart ##0 ctl_ff[CTL_CTS]
        |-> !$past(clear_to_send_n, 4))
        else $error("frame started without clear-to-send");
    a_frame_len: assert property ($fell(pins.txActive)
        |-> txLen_ff >= MIN_FRAME)
        else $error("frame cut short");
    a_rts_off: assert property (!ctl_ff[CTL_RTS] && !$past(ctl_ff[CTL_RTS])
        |-> pins.rtsN)
        else $error("rts driven while disabled");
    a_rts_on: assert property ($rose(ctl_ff[CTL_REN]) && ctl_ff[CTL_RTS]
        |-> ##[1:3] !pins.rtsN)
        else $error("rts not low after receive enable");
    a_rts_start: assert property (ctl_ff[CTL_REN] && ctl_ff[CTL_RTS]
        && $fell(rxd) |-> ##[1:100] pins.rtsN)
        else $error("rts not high after start bit");
    a_rx_stop: assert property (irq.rxFullIrq |-> $past(rxd, 6))
        else $error("receive interrupt without stop bit");
endmodule
bind uif_uart uif_uart_properties uif_uart_properties_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .clear_to_send_n(clear_to_send_n), .pins(pins), .irq(irq)
);

//--- test/uif_remote.sv
// Remote serial station: frame sender and listener on the far side
`timescale 1ns/1ps
module uif_remote
    import uif_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic txd, // Line from the channel
    input wire logic rtsN, // Permission to send, low
    input wire logic hold, // Keep clear-to-send off
    output logic rxd, // Line into the channel
    output logic clear_to_send_n, // Permission to receive
    output logic [7:0] lastTx // Last character heard
);
    import uif_pkg::*;
    logic [7:0] sh;
    assign clear_to_send_n = hold;
    initial rxd = 1'b1;
    // Start, eight data bits, stop, one idle bit
    task automatic sendChar(input logic [7:0] d, input bit bad);
        int i;
        @(posedge clk_sys);
        while (rtsN !== 1'b0)
            @(posedge clk_sys);
        for (i = 0; i < 11; i++)
        begin
            rxd <= (i == 0) ? 1'b0 : (i < 9) ? d[i - 1]
                : (i == 9) ? !bad : 1'b1;
            repeat (BIT_DIV) @(posedge clk_sys);
        end
    endtask
    always
    begin
        @(negedge txd);
        repeat (HALF_DIV) @(posedge clk_sys);
        for (int j = 0; j < 8; j++)
        begin
            repeat (BIT_DIV) @(posedge clk_sys);
            sh[j] = txd;
        end
        lastTx <= sh;
        repeat (BIT_DIV) @(posedge clk_sys);
    end
endmodule

//--- test/tb_top.sv
// Testbench: APB master, remote station and checks of the channel
`timescale 1ns/1ps
module tb_top;
    import uif_pkg::*;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, hold = 0;
    logic [7:0] paddr = 8'h00, lastTx;
    logic [31:0] pwdata = 32'h0, prdata, rdv, seed = 32'h0000004B;
    logic pready, pslverr, rxd, clear_to_send_n, errv;
    uif_pins_t pins;
    uif_irq_t irq;
    int failures = 0, n_tests = 0, nTx = 0, nRx = 0, nErr = 0, cyc = 0;
    uif_uart uif_uart_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .clear_to_send_n(clear_to_send_n), .pins(pins), .irq(irq));
    uif_remote uif_remote_inst (.clk_sys(clk_sys), .txd(pins.txd),
        .rtsN(pins.rtsN), .hold(hold), .rxd(rxd),
        .clear_to_send_n(clear_to_send_n), .lastTx(lastTx));
    always #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        cyc++;
        if (irq.txIrq === 1'b1)
            nTx++;
        if (irq.rxFullIrq === 1'b1)
            nRx++;
        if (irq.errSumIrq === 1'b1)
            nErr++;
        if (cyc == 40000)
        begin
            failures++;
            summarize();
        end
    end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Expected status word
    function automatic logic [31:0] st(input bit b, input bit o, input bit f);
        return 32'h3 | (32'(b) << ST_RBF) | (32'(o) << ST_OER)
            | (32'(f) << ST_FER) | (32'(o | f) << ST_SER);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rdv & m, e);
    endtask
    task automatic wtx(input logic v);
        for (int i = 0; i < 3000 && pins.txActive !== v; i++)
            @(posedge clk_sys);
        chk(pins.txActive, v);
    endtask
    task automatic summarize();
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int k, n;
        logic [7:0] b;
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rd(ADDR_STAT, 32'hFF, st(0, 0, 0));
        rd(8'h14, 32'hFFFFFFFF, 32'h0);
        chk(errv, 1'b1);
        // Plain transmit, buffer-empty interrupt
        wr(ADDR_CTRL, 32'h01);
        for (k = 0; k < 2; k++)
        begin
            b = xs();
            wr(ADDR_TXRX, {24'h0, b});
            wtx(1);
            wtx(0);
            chk(lastTx, b);
        end
        chk(nTx, 2);
        // Clear-to-send gating
        hold <= 1;
        wr(ADDR_CTRL, 32'h21);
        wr(ADDR_TXRX, 32'hA5);
        repeat (300) @(posedge clk_sys);
        chk(pins.txActive, 1'b0);
        hold <= 0;
        wtx(1);
        hold <= 1;
        wtx(0);
        chk(lastTx, 8'hA5);
        // Complete interrupt, enable dropped mid-frame
        hold <= 0;
        wr(ADDR_CTRL, 32'h11);
        n = nTx;
        wr(ADDR_TXRX, 32'h3C);
        wtx(1);
        wr(ADDR_CTRL, 32'h10);
        chk(nTx, n);
        wtx(0);
        repeat (5) @(posedge clk_sys);
        chk(nTx, n + 1);
        chk(lastTx, 8'h3C);
        // Receive with request-to-send delay of eight bit-times
        wr(ADDR_DLY, 32'h1);
        wr(ADDR_CTRL, 32'h42);
        b = xs() | 8'h80;
        uif_remote_inst.sendChar(b, 0);
        repeat (420) @(posedge clk_sys);
        chk(pins.rtsN, 1'b1);
        repeat (200) @(posedge clk_sys);
        chk(pins.rtsN, 1'b0);
        chk(nRx, 1);
        rd(ADDR_TXRX, 32'hFF, {24'h0, b});
        // Framing error, status clears on read
        wr(ADDR_DLY, 32'h0);
        uif_remote_inst.sendChar(8'h55, 1);
        chk(nErr, 1);
        rd(ADDR_STAT, 32'hFF, st(0, 0, 1));
        rd(ADDR_STAT, 32'hFF, st(0, 0, 0));
        // Overrun outside address mode
        uif_remote_inst.sendChar(8'h81, 0);
        uif_remote_inst.sendChar(8'h02, 0);
        rd(ADDR_STAT, 32'hFF, st(1, 1, 0));
        chk(nErr, 2);
        chk(nRx, 2);
        apb(0, ADDR_TXRX, 32'h0);
        // Address mode
        wr(ADDR_MODE, 32'h08);
        n = nRx;
        uif_remote_inst.sendChar(8'h12, 0);
        uif_remote_inst.sendChar(8'h34, 0);
        chk(nRx, n);
        rd(ADDR_STAT, 32'hFF, st(1, 0, 0));
        uif_remote_inst.sendChar(8'h85, 0);
        chk(nRx, n + 1);
        rd(ADDR_MODE, 32'hFF, 32'h0);
        rd(ADDR_TXRX, 32'hFF, 32'h85);
        summarize();
    end
endmodule
